// ---- design/pcr_msg_handler.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcr_msg_handler
  import pcr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  // request byte stream, same clock domain
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  input wire logic rx_bcast_in,
  output logic rx_ready_out,
  // response byte stream
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  // internal register port
  output logic reg_rd_out,
  output logic [15:0] reg_addr_out,
  input wire logic [15:0] reg_rdata_in,
  output logic param_wr_out,
  output logic [15:0] param_wdata_out,
  output logic param_stage_out,
  input wire logic param_bad_in,
  // apply control
  input wire logic apply_mode_in,
  input wire logic undervolt_in,
  input wire logic nvm_done_in,
  input wire logic nvm_busy_in,
  input wire logic power_up_in,
  output logic apply_ram_out,
  output logic nvm_write_out,
  output logic related_adjust_out,
  output logic full_limit_check_out,
  output logic nvm_data_error_indication_out
);
  pcr_state_type state_q;
  pcr_cmd_type cmd_q;
  logic [2:0] hdr_cnt_q;
  logic [4:0] cnt_q;
  logic [4:0] idx_q;
  logic [5:0] tx_idx_q;
  logic [5:0] tx_len_q;
  logic err_q;
  logic [7:0] exc_q;
  logic bcast_q;
  logic [15:0] rdbuf_q [0:15];
  logic commit_nv;
  logic commit_vol;
  logic nvm_abort;
  logic abort_seen_q;
  logic [15:0] end_addr;
  logic hits_commit;
  logic [7:0] tx_byte;
  logic [15:0] tx_word;
  logic [5:0] tx_off;
  logic err_next;
  logic uv_meta_q;
  logic uv_sync_q;
  logic pu_meta_q;
  logic pu_sync_q;

  assign rx_ready_out = (state_q == PCR_IDLE) || (state_q == PCR_HDR) || (state_q == PCR_FIELD);
  assign full_limit_check_out = ~apply_mode_in;
  assign related_adjust_out = apply_mode_in;

  // header: unit id, function, address hi/lo, value-or-count hi/lo
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= PCR_IDLE;
      cmd_q <= '0;
      hdr_cnt_q <= 3'h0;
      bcast_q <= 1'b0;
    end else begin
      case (state_q)
        PCR_IDLE: begin
          if (rx_valid_in) begin
            cmd_q.unit_id <= rx_data_in;
            bcast_q <= rx_bcast_in;
            hdr_cnt_q <= 3'h1;
            state_q <= rx_last_in ? PCR_DECIDE : PCR_HDR;
          end
        end
        PCR_HDR: begin
          if (rx_valid_in) begin
            cmd_q.func <= rx_data_in;
            hdr_cnt_q <= 3'h2;
            state_q <= rx_last_in ? PCR_DECIDE : PCR_FIELD;
          end
        end
        PCR_FIELD: begin
          if (rx_valid_in) begin
            case (hdr_cnt_q)
              3'h2: cmd_q.addr[15:8] <= rx_data_in;
              3'h3: cmd_q.addr[7:0] <= rx_data_in;
              3'h4: cmd_q.value[15:8] <= rx_data_in;
              3'h5: cmd_q.value[7:0] <= rx_data_in;
              default: ;
            endcase
            if (hdr_cnt_q != 3'h7) begin
              hdr_cnt_q <= hdr_cnt_q + 3'h1;
            end
            if (rx_last_in) begin
              state_q <= PCR_DECIDE;
            end
          end
        end
        PCR_DECIDE: begin
          state_q <= (!err_next && cmd_q.func == PCR_FC_READ) ? PCR_READ : PCR_SEND;
        end
        PCR_READ: begin
          if (idx_q + 5'h1 == cnt_q) begin
            state_q <= PCR_SEND;
          end
        end
        PCR_SEND: begin
          if (bcast_q || (tx_ready_in && tx_idx_q + 6'h1 == tx_len_q)) begin
            state_q <= PCR_DONE;
          end
        end
        PCR_DONE: state_q <= PCR_IDLE;
        default: state_q <= PCR_IDLE;
      endcase
    end
  end

  // base-one network addressing
  assign end_addr = cmd_q.addr + PCR_ADDR_BASE_ADJ + {11'h000, cmd_q.value[4:0]} - 16'h0001;
  // read range that covers a commit register is refused
  assign hits_commit = ((cmd_q.addr + PCR_ADDR_BASE_ADJ <= PCR_REG_COMMIT_NV) && (end_addr >= PCR_REG_COMMIT_NV))
    || ((cmd_q.addr + PCR_ADDR_BASE_ADJ <= PCR_REG_COMMIT_VOL) && (end_addr >= PCR_REG_COMMIT_VOL));

  // a plain signal rather than a function, so every reader sees the settled header
  always_comb begin
    err_next = 1'b0;
    if (hdr_cnt_q != 3'h6) begin
      err_next = 1'b1;
    end else if (cmd_q.func == PCR_FC_READ) begin
      err_next = (cmd_q.value == 16'h0000) || (cmd_q.value > {11'h000, PCR_MAX_COUNT}) || hits_commit;
    end else if (cmd_q.func == PCR_FC_WRITE1) begin
      err_next = param_bad_in;
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      err_q <= 1'b0;
      exc_q <= 8'h00;
      cnt_q <= 5'h00;
    end else if (state_q == PCR_DECIDE) begin
      err_q <= err_next;
      cnt_q <= cmd_q.value[4:0];
      if (cmd_q.func != PCR_FC_READ && cmd_q.func != PCR_FC_WRITE1) begin
        exc_q <= PCR_EXC_ILLEGAL_FUNC;
      end else if (cmd_q.func == PCR_FC_READ && !hits_commit) begin
        exc_q <= PCR_EXC_BAD_VALUE;
      end else if (cmd_q.func == PCR_FC_READ) begin
        exc_q <= PCR_EXC_BAD_ADDR;
      end else begin
        exc_q <= PCR_EXC_BAD_VALUE;
      end
    end
  end

  // staged register reads into a local block buffer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      idx_q <= 5'h00;
    end else if (state_q == PCR_READ) begin
      idx_q <= idx_q + 5'h01;
    end else begin
      idx_q <= 5'h00;
    end
  end

  always_ff @(posedge clock_in) begin
    if (state_q == PCR_READ) begin
      rdbuf_q[idx_q[3:0]] <= reg_rdata_in;
    end
  end

  assign reg_rd_out = (state_q == PCR_READ);
  assign reg_addr_out = cmd_q.addr + PCR_ADDR_BASE_ADJ + {11'h000, idx_q};

  // write path: zero written to a commit register goes to the commit controller, writes to other addresses raise param_wr_out
  assign commit_nv = (state_q == PCR_DECIDE) && !err_next && cmd_q.func == PCR_FC_WRITE1
    && (cmd_q.addr + PCR_ADDR_BASE_ADJ == PCR_REG_COMMIT_NV) && (cmd_q.value == PCR_COMMIT_VALUE);
  assign commit_vol = (state_q == PCR_DECIDE) && !err_next && cmd_q.func == PCR_FC_WRITE1
    && (cmd_q.addr + PCR_ADDR_BASE_ADJ == PCR_REG_COMMIT_VOL) && (cmd_q.value == PCR_COMMIT_VALUE);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      param_wr_out <= 1'b0;
      param_stage_out <= 1'b0;
      param_wdata_out <= 16'h0000;
    end else begin
      param_wr_out <= (state_q == PCR_DECIDE) && !err_next && cmd_q.func == PCR_FC_WRITE1
        && !commit_nv && !commit_vol
        && (cmd_q.addr + PCR_ADDR_BASE_ADJ != PCR_REG_COMMIT_NV)
        && (cmd_q.addr + PCR_ADDR_BASE_ADJ != PCR_REG_COMMIT_VOL);
      // only broadcast bypasses staging in mode zero; mode one applies at once
      param_stage_out <= ~apply_mode_in & ~bcast_q;
      param_wdata_out <= cmd_q.value;
    end
  end

  // response: length and byte selection
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_len_q <= 6'h00;
    end else if (state_q == PCR_DECIDE) begin
      if (err_next) begin
        tx_len_q <= 6'h03;
      end else if (cmd_q.func == PCR_FC_READ) begin
        tx_len_q <= 6'h03 + {cmd_q.value[4:0], 1'b0};
      end else begin
        tx_len_q <= 6'h06;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_idx_q <= 6'h00;
    end else if (state_q == PCR_SEND && tx_ready_in) begin
      tx_idx_q <= tx_idx_q + 6'h01;
    end else if (state_q != PCR_SEND) begin
      tx_idx_q <= 6'h00;
    end
  end

  // first data byte sits at index 3, two bytes per buffered word
  assign tx_off = tx_idx_q - 6'h03;
  assign tx_word = rdbuf_q[tx_off[4:1]];

  always_comb begin
    tx_byte = 8'h00;
    if (tx_idx_q == 6'h00) begin
      tx_byte = cmd_q.unit_id;
    end else if (tx_idx_q == 6'h01) begin
      tx_byte = err_q ? (cmd_q.func | PCR_FC_ERR_BIT) : cmd_q.func;
    end else if (err_q) begin
      tx_byte = exc_q;
    end else if (cmd_q.func == PCR_FC_READ) begin
      if (tx_idx_q == 6'h02) begin
        tx_byte = {2'b00, cnt_q, 1'b0};
      end else begin
        tx_byte = tx_idx_q[0] ? tx_word[15:8] : tx_word[7:0];
      end
    end else begin
      case (tx_idx_q)
        6'h02: tx_byte = cmd_q.addr[15:8];
        6'h03: tx_byte = cmd_q.addr[7:0];
        6'h04: tx_byte = cmd_q.value[15:8];
        default: tx_byte = cmd_q.value[7:0];
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_data_out <= 8'h00;
    end else begin
      tx_data_out <= tx_byte;
    end
  end

  // data is registered one cycle behind the index, so valid lags too
  logic tx_pending_q;
  logic tx_last_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_pending_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else begin
      tx_pending_q <= (state_q == PCR_SEND) && !bcast_q && tx_ready_in;
      tx_last_q <= (state_q == PCR_SEND) && tx_idx_q + 6'h1 == tx_len_q;
    end
  end
  assign tx_valid_out = tx_pending_q;
  assign tx_last_out = tx_pending_q & tx_last_q;

  // supply monitor signals are asynchronous to this clock, so two flops first
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      uv_meta_q <= 1'b0;
      uv_sync_q <= 1'b0;
      pu_meta_q <= 1'b0;
      pu_sync_q <= 1'b0;
    end else begin
      uv_meta_q <= undervolt_in;
      uv_sync_q <= uv_meta_q;
      pu_meta_q <= power_up_in;
      pu_sync_q <= pu_meta_q;
    end
  end

  pcr_commit_ctrl u_commit (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .commit_nv_in(commit_nv),
    .commit_vol_in(commit_vol),
    .undervolt_in(uv_sync_q),
    .nvm_done_in(nvm_done_in),
    .nvm_busy_in(nvm_busy_in),
    .apply_ram_out(apply_ram_out),
    .nvm_write_out(nvm_write_out),
    .nvm_abort_out(nvm_abort)
  );

  // abort remembered until reset and reported at each power-up; an abort in the power-up cycle is reported too
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      abort_seen_q <= 1'b0;
      nvm_data_error_indication_out <= 1'b0;
    end else begin
      if (nvm_abort) begin
        abort_seen_q <= 1'b1;
      end
      if (pu_sync_q) begin
        nvm_data_error_indication_out <= abort_seen_q | nvm_abort;
      end
    end
  end

  a_err_fc_bit: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_SEND && tx_idx_q == 6'h01 && err_q |=> tx_data_out[7])
    else $error("error response without top function bit");
  a_uid_echo: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_SEND && tx_idx_q == 6'h00 |=> tx_data_out == cmd_q.unit_id)
    else $error("unit id not echoed");
  a_count_range: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_DECIDE && cmd_q.func == PCR_FC_READ && cmd_q.value > 16'h0010 |=> err_q)
    else $error("out of range count accepted");
  a_count_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_DECIDE && cmd_q.func == PCR_FC_READ && cmd_q.value == 16'h0000 |=> err_q)
    else $error("zero count accepted");
  a_err_len: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_DECIDE && err_next |=> tx_len_q == 6'h03)
    else $error("error response length wrong");
  a_read_commit: assert property (@(posedge clock_in) disable iff (rst_in)
    state_q == PCR_DECIDE && cmd_q.func == PCR_FC_READ && hits_commit |=> err_q)
    else $error("commit register read returned data");
endmodule : pcr_msg_handler
`default_nettype wire

// ---- design/pcr_pkg.sv ----
// Contract
// - writing zero to either commit register starts a commit, and the device acts on it.
// - commit registers accept writes only; they are write-only locations.
// - a read touching either commit register returns an error response, no data.
// - persistent commit writes nonvolatile storage and applies to working memory together.
// - volatile commit updates working memory only; nonvolatile storage is untouched.
// - command data and broadcast messages take effect with no commit; here only broadcast bypasses staging in mode zero, where command data is staged.
// - no nonvolatile write while undervoltage is present, even on persistent commit.
// - undervoltage aborting a persistent commit leaves a data error flagged at power-up.
// - apply mode zero: changes take effect on commit; related limits considered.
// - apply mode one: changes take effect on write; own limits only.
// - apply mode one adjusts related defaults; mode zero leaves them unchanged.
// - apply mode one: one invalid value in a block discards all of it.
// - every message is unit id byte, function code byte, then data field.
// - response unit id equals the command's unit id.
// - response echoes function code, top bit set on error.
// - read-block response: code 03, byte count 2N, values high byte first.
// - failed read-block answers unit id, code 83, one exception byte.
// - received register addresses are incremented by one before internal access.
package pcr_pkg;
  localparam logic [15:0] PCR_REG_COMMIT_NV = 16'h0900;
  localparam logic [15:0] PCR_REG_COMMIT_VOL = 16'h0910;
  localparam logic [15:0] PCR_COMMIT_VALUE = 16'h0000;
  localparam logic [7:0] PCR_FC_READ = 8'h03;
  localparam logic [7:0] PCR_FC_WRITE1 = 8'h06;
  localparam logic [7:0] PCR_FC_ERR_BIT = 8'h80;
  localparam logic [7:0] PCR_EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] PCR_EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] PCR_EXC_BAD_VALUE = 8'h03;
  localparam logic [4:0] PCR_MAX_COUNT = 5'h10;
  localparam logic [15:0] PCR_ADDR_BASE_ADJ = 16'h0001;

  typedef struct packed {
    logic [7:0] unit_id;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] value;
  } pcr_cmd_type;

  typedef enum logic [6:0] {
    PCR_IDLE = 7'b0000001,
    PCR_HDR = 7'b0000010,
    PCR_FIELD = 7'b0000100,
    PCR_DECIDE = 7'b0001000,
    PCR_READ = 7'b0010000,
    PCR_SEND = 7'b0100000,
    PCR_DONE = 7'b1000000
  } pcr_state_type;
endpackage : pcr_pkg

// ---- design/pcr_commit_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcr_commit_ctrl
  import pcr_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic commit_nv_in,
  input wire logic commit_vol_in,
  input wire logic undervolt_in,
  input wire logic nvm_done_in,
  input wire logic nvm_busy_in,
  output logic apply_ram_out,
  output logic nvm_write_out,
  output logic nvm_abort_out
);
  logic nv_active_q;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      apply_ram_out <= 1'b0;
    end else begin
      apply_ram_out <= commit_nv_in | commit_vol_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      nvm_write_out <= 1'b0;
    end else begin
      // persistent commit only, and never while undervoltage is present
      nvm_write_out <= commit_nv_in & ~undervolt_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      nv_active_q <= 1'b0;
      nvm_abort_out <= 1'b0;
    end else begin
      nvm_abort_out <= nv_active_q & nvm_busy_in & undervolt_in;
      if (commit_nv_in & ~undervolt_in) begin
        nv_active_q <= 1'b1;
      end else if (nvm_done_in | (nvm_busy_in & undervolt_in)) begin
        nv_active_q <= 1'b0;
      end
    end
  end

  a_nv_blocked_uv: assert property (@(posedge clock_in) disable iff (rst_in)
    commit_nv_in && undervolt_in |=> !nvm_write_out)
    else $error("nonvolatile write under undervoltage");
  a_vol_no_nv: assert property (@(posedge clock_in) disable iff (rst_in)
    commit_vol_in && !commit_nv_in |=> apply_ram_out && !nvm_write_out)
    else $error("volatile commit touched nonvolatile storage");
  a_nv_both: assert property (@(posedge clock_in) disable iff (rst_in)
    commit_nv_in && !undervolt_in |=> apply_ram_out && nvm_write_out)
    else $error("persistent commit did not apply both");
endmodule : pcr_commit_ctrl
`default_nettype wire

// ---- verification/pcr_drive_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pcr_drive_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic nvm_write_in,
  output logic [15:0] reg_rdata_out,
  output logic nvm_busy_out,
  output logic nvm_done_out
);
  logic [3:0] left_q;
  // data folds the address, so an offset slip shows up in the payload
  assign reg_rdata_out = {reg_addr_in[7:0], ~reg_addr_in[15:8]};
  assign nvm_busy_out = (left_q != 4'h0);
  // storage stays busy for eight cycles after each write
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      left_q <= 4'h0;
      nvm_done_out <= 1'b0;
    end else begin
      nvm_done_out <= (left_q == 4'h1);
      if (nvm_write_in) begin
        left_q <= 4'h8;
      end else if (left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
      end
    end
  end
endmodule : pcr_drive_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pcr_pkg::*;
;
  logic clock_in = 0, rst_in = 1, rx_valid_in = 0, rx_last_in = 0, rx_bcast_in = 0;
  logic tx_ready_in = 1, param_bad_in = 0, apply_mode_in = 0, undervolt_in = 0, power_up_in = 0;
  logic [7:0] rx_data_in = 8'h00;
  logic rx_ready_out, tx_valid_out, tx_last_out, reg_rd_out, param_wr_out, param_stage_out;
  logic apply_ram_out, nvm_write_out, related_adjust_out, full_limit_check_out;
  logic nvm_data_error_indication_out, nvm_done_in, nvm_busy_in, stage_seen, stall = 0, cut = 0, uv_set = 0;
  logic [7:0] tx_data_out;
  logic [15:0] reg_addr_out, reg_rdata_in, param_wdata_out, wdata_seen;
  int n_mismatch = 0, compares = 0, n_nvw = 0, n_app = 0, n_pwr = 0, n_rd = 0, s_nvw, s_app, s_pwr;
  logic [7:0] rsp[$];
  logic [7:0] exp[$];
  always #25 clock_in = ~clock_in;
  pcr_msg_handler pcr_msg_handler_i (.clock_in, .rst_in, .rx_valid_in, .rx_data_in, .rx_last_in,
    .rx_bcast_in, .rx_ready_out, .tx_valid_out, .tx_data_out, .tx_last_out, .tx_ready_in,
    .reg_rd_out, .reg_addr_out, .reg_rdata_in, .param_wr_out, .param_wdata_out, .param_stage_out,
    .param_bad_in, .apply_mode_in, .undervolt_in, .nvm_done_in, .nvm_busy_in, .power_up_in,
    .apply_ram_out, .nvm_write_out, .related_adjust_out, .full_limit_check_out,
    .nvm_data_error_indication_out);
  pcr_drive_model pcr_drive_model_i (.clock_in, .rst_in, .reg_addr_in(reg_addr_out),
    .nvm_write_in(nvm_write_out), .reg_rdata_out(reg_rdata_in), .nvm_busy_out(nvm_busy_in),
    .nvm_done_out(nvm_done_in));
  always @(posedge clock_in) begin
    if (nvm_write_out === 1'b1) n_nvw++;
    if (apply_ram_out === 1'b1) n_app++;
    if (param_wr_out === 1'b1) n_pwr++;
    if (param_wr_out === 1'b1) stage_seen = param_stage_out;
    if (param_wr_out === 1'b1) wdata_seen = param_wdata_out;
    if (reg_rd_out === 1'b1) n_rd++;
    // brown-out arriving while storage is being written, held while cut stands
    undervolt_in <= uv_set | (cut & (undervolt_in | (nvm_write_out === 1'b1)));
    tx_ready_in <= stall ? ~tx_ready_in : 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic req(input logic [7:0] uid, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    logic [47:0] m;
    m = {uid, fc, a, v};
    rsp.delete();
    for (int i = 0; i < 6; i++) begin
      rx_valid_in = 1'b1;
      rx_data_in = m[47-8*i -: 8];
      rx_last_in = (i == 5);
      for (int k = 0; k < 50 && rx_ready_out !== 1'b1; k++) begin
        @(posedge clock_in);
        #5;
      end
      @(posedge clock_in);
      #5;
    end
    rx_valid_in = 1'b0;
    rx_last_in = 1'b0;
    for (int k = 0; k < 300; k++) begin
      // a byte stands for one cycle after the ready edge that released it
      if (tx_valid_out === 1'b1) rsp.push_back(tx_data_out);
      if (tx_valid_out === 1'b1 && tx_last_out === 1'b1) break;
      @(posedge clock_in);
      #5;
    end
    @(posedge clock_in);
    #5;
  endtask : req
  task automatic verify();
    chk(16'(rsp.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < rsp.size()) chk(16'(rsp[i]), 16'(exp[i]));
    end
  endtask : verify
  task automatic rd(input logic [15:0] a, input logic [15:0] n, input logic [7:0] ex);
    logic [15:0] w;
    logic [15:0] ia;
    req(a[7:0] ^ 8'h3C, PCR_FC_READ, a, n);
    exp = {a[7:0] ^ 8'h3C};
    if (ex != 8'h00) begin
      exp = {exp, PCR_FC_READ | PCR_FC_ERR_BIT, ex};
    end else begin
      exp = {exp, PCR_FC_READ, 8'(2 * n)};
      for (int i = 1; i <= n; i++) begin
        ia = a + 16'(i);
        w = {ia[7:0], ~ia[15:8]};
        exp = {exp, w[15:8], w[7:0]};
      end
    end
    verify();
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic [7:0] ex);
    s_nvw = n_nvw;
    s_app = n_app;
    s_pwr = n_pwr;
    req(8'hC3, PCR_FC_WRITE1, a, v);
    if (ex != 8'h00) exp = {8'hC3, PCR_FC_WRITE1 | PCR_FC_ERR_BIT, ex};
    else exp = {8'hC3, PCR_FC_WRITE1, a[15:8], a[7:0], v[15:8], v[7:0]};
    // a broadcast is never answered
    if (rx_bcast_in) exp.delete();
    verify();
    repeat (40) @(posedge clock_in);
    #5;
  endtask : wr
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    #(50 * 40000);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (12) @(posedge clock_in);
    #5 rst_in = 1'b0;
    @(posedge clock_in);
    #5;
    rd(16'h001F, 16'h0004, 8'h00);
    stall = 1'b1;
    rd(16'h0100, 16'h0010, 8'h00);
    stall = 1'b0;
    rd(16'h0100, 16'h0000, PCR_EXC_BAD_VALUE);
    rd(16'h0100, 16'h0011, PCR_EXC_BAD_VALUE);
    rd(16'h08FF, 16'h0001, PCR_EXC_BAD_ADDR);
    rd(16'h0905, 16'h000C, PCR_EXC_BAD_ADDR);
    rd(16'h08FE, 16'h0001, 8'h00);
    req(8'h11, 8'h04, 16'h0000, 16'h0001);
    exp = {8'h11, 8'h84, PCR_EXC_ILLEGAL_FUNC};
    verify();
    chk(16'(n_rd), 16'h0015);
    $display("test reads done");
    wr(PCR_REG_COMMIT_NV - PCR_ADDR_BASE_ADJ, PCR_COMMIT_VALUE, 8'h00);
    chk(16'(n_nvw - s_nvw), 16'h0001);
    chk(16'(n_app - s_app), 16'h0001);
    wr(PCR_REG_COMMIT_VOL - PCR_ADDR_BASE_ADJ, PCR_COMMIT_VALUE, 8'h00);
    chk(16'(n_nvw - s_nvw), 16'h0000);
    chk(16'(n_app - s_app), 16'h0001);
    uv_set = 1'b1;
    wr(PCR_REG_COMMIT_NV - PCR_ADDR_BASE_ADJ, PCR_COMMIT_VALUE, 8'h00);
    chk(16'(n_nvw - s_nvw), 16'h0000);
    uv_set = 1'b0;
    $display("test commits done");
    wr(16'h0040, 16'h1234, 8'h00);
    chk(16'(n_pwr - s_pwr), 16'h0001);
    chk(16'(stage_seen), 16'h0001);
    chk(wdata_seen, 16'h1234);
    chk(16'(n_app - s_app), 16'h0000);
    chk(16'(related_adjust_out), 16'h0000);
    chk(16'(full_limit_check_out), 16'h0001);
    apply_mode_in = 1'b1;
    wr(16'h0041, 16'h4321, 8'h00);
    chk(16'(stage_seen), 16'h0000);
    chk(16'(related_adjust_out), 16'h0001);
    chk(16'(full_limit_check_out), 16'h0000);
    param_bad_in = 1'b1;
    wr(16'h0041, 16'hFFFF, PCR_EXC_BAD_VALUE);
    chk(16'(n_pwr - s_pwr), 16'h0000);
    param_bad_in = 1'b0;
    apply_mode_in = 1'b0;
    rx_bcast_in = 1'b1;
    wr(16'h0042, 16'h00FF, 8'h00);
    chk(16'(n_pwr - s_pwr), 16'h0001);
    chk(16'(stage_seen), 16'h0000);
    rx_bcast_in = 1'b0;
    $display("test apply modes done");
    cut = 1'b1;
    wr(PCR_REG_COMMIT_NV - PCR_ADDR_BASE_ADJ, PCR_COMMIT_VALUE, 8'h00);
    cut = 1'b0;
    power_up_in = 1'b1;
    @(posedge clock_in);
    #5 power_up_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #5;
    chk(16'(nvm_data_error_indication_out), 16'h0001);
    uv_set = 1'b0;
    $display("test brown-out done");
    results();
  end
endmodule : tb_top
`default_nettype wire
